//--- dv/tb.sv
// Self-checking testbench for the converter trim register bank
`timescale 1ns/10ps

module tb;
  import ctb_pkg::*;

  logic        clk_sys   = 1'b0;
  logic        rst       = 1'b1;
  logic        hsel      = 1'b0;
  logic [31:0] haddr     = 32'h0;
  logic [1:0]  htrans    = 2'h0;
  logic        hwrite    = 1'b0;
  logic [2:0]  hsize     = 3'h2;
  logic [31:0] hwdata    = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [7:0]  a_tim;
  logic [7:0]  b_tim;
  logic [11:0] a_ofs;
  logic        a_tim_v;
  logic        b_tim_v;
  logic        a_ofs_v;
  logic [31:0] rd;
  logic [11:0] fuse [7]  = '{12'h05a, 12'h0c3, 12'h07e, 12'h9a1, 12'h4b2, 12'h6c3, 12'hfd4};
  logic [15:0] regv [7];
  logic [9:0]  idx  [7]  = '{IDX_B_SINGLE_INA_TIM, IDX_A_SINGLE_INB_TIM, IDX_B_SINGLE_INB_TIM,
                            IDX_A_DUAL_INA_OFS, IDX_A_DUAL_INB_OFS, IDX_A_SINGLE_INA_OFS,
                            IDX_A_SINGLE_INB_OFS};
  int          fail_count = 0;
  int          tests_run  = 0;
  int          cycles     = 0;

  always #20 clk_sys = ~clk_sys;

  ctb_trim_bank dut (
    .CLK_SYS(clk_sys), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .FUSE_B_SINGLE_INA_TIM(fuse[0][7:0]), .FUSE_A_SINGLE_INB_TIM(fuse[1][7:0]),
    .FUSE_B_SINGLE_INB_TIM(fuse[2][7:0]), .FUSE_A_DUAL_INA_OFS(fuse[3]),
    .FUSE_A_DUAL_INB_OFS(fuse[4]), .FUSE_A_SINGLE_INA_OFS(fuse[5]),
    .FUSE_A_SINGLE_INB_OFS(fuse[6]),
    .CORE_A_TIMING_TRIM(a_tim), .CORE_A_TIMING_VALID(a_tim_v),
    .CORE_B_TIMING_TRIM(b_tim), .CORE_B_TIMING_VALID(b_tim_v),
    .CORE_A_OFFSET_TRIM(a_ofs), .CORE_A_OFFSET_VALID(a_ofs_v)
  );

  task automatic summarize();
    $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Values taken just before the edge that samples hready
  task automatic bus_wait(output logic [31:0] data);
    logic rdy;
    do begin
      @(negedge clk_sys);
      rdy = hreadyout;
      data = hrdata;
      @(posedge clk_sys);
    end while (rdy !== 1'b1);
  endtask

  task automatic xfer(input logic wr, input logic [9:0] ix, input logic [2:0] sz,
                      input logic [31:0] wd, output logic [31:0] data);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= sz;
    haddr <= {20'h0, ix, 2'h0};
    bus_wait(data);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    bus_wait(data);
  endtask

  function automatic logic [31:0] rexp(input int i, input logic [15:0] v);
    return (i < 3) ? {24'h0, v[7:0]} : {16'h0, v};
  endfunction

  // Expected routing worked out from the control bits
  task automatic check_sel(input logic [3:0] c);
    logic [7:0]  ea;
    logic [7:0]  eb;
    logic [11:0] eo;
    logic [2:0]  ev;
    ea = 8'h0;
    eb = 8'h0;
    eo = 12'h0;
    ev = 3'h0;
    if (c[CTRL_FG_CAL]) begin
      ev[STAT_A_OFS] = 1'b1;
      if (c[CTRL_SINGLE]) begin
        eb = c[CTRL_B_INB] ? regv[2][7:0] : regv[0][7:0];
        ev[STAT_B_TIM] = 1'b1;
        ea = c[CTRL_A_INB] ? regv[1][7:0] : 8'h0;
        ev[STAT_A_TIM] = c[CTRL_A_INB];
        eo = c[CTRL_A_INB] ? regv[6][11:0] : regv[5][11:0];
      end else begin
        eo = c[CTRL_A_INB] ? regv[4][11:0] : regv[3][11:0];
      end
    end
    // Trim outputs move at the write edge; look half a cycle later
    @(negedge clk_sys);
    check("b timing", {24'h0, b_tim}, {24'h0, eb});
    check("a timing", {24'h0, a_tim}, {24'h0, ea});
    check("a offset", {20'h0, a_ofs}, {20'h0, eo});
    check("valids", {29'h0, a_ofs_v, b_tim_v, a_tim_v}, {29'h0, ev});
    @(posedge clk_sys);
    xfer(1'b0, IDX_TRIM_STATUS, HSIZE_WORD, 32'h0, rd);
    check("status", rd, {29'h0, ev});
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask

  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 7; i++) begin
      xfer(1'b0, idx[i], HSIZE_WORD, 32'h0, rd);
      check("fuse reset value", rd, rexp(i, {4'h0, fuse[i]}));
    end
    check("outputs after reset", {29'h0, a_ofs_v, b_tim_v, a_tim_v}, 32'h0);
    $display("Test reset values done");
    // Half-word write must be refused and leave the fuse value
    xfer(1'b1, idx[0], 3'h1, 32'hffff_ffff, rd);
    xfer(1'b0, idx[0], HSIZE_WORD, 32'h0, rd);
    check("non-word write", rd, rexp(0, {4'h0, fuse[0]}));
    for (int i = 0; i < 7; i++) begin
      regv[i] = 16'ha5c3 ^ (16'h1111 * i[15:0]);
      xfer(1'b1, idx[i], HSIZE_WORD, {16'hdead, regv[i]}, rd);
      xfer(1'b0, idx[i], HSIZE_WORD, 32'h0, rd);
      check("readback", rd, rexp(i, regv[i]));
    end
    xfer(1'b1, 10'h3ff, HSIZE_WORD, 32'hffff_ffff, rd);
    xfer(1'b0, 10'h3ff, HSIZE_WORD, 32'h0, rd);
    check("unmapped read", rd, 32'h0);
    $display("Test register access done");
    for (int c = 0; c < 16; c++) begin
      xfer(1'b1, IDX_TRIM_CTRL, HSIZE_WORD, {28'h0, c[3:0]}, rd);
      check_sel(c[3:0]);
    end
    $display("Test trim routing done");
    // Second reset reloads the fuse values over software writes
    fuse[0] <= 12'h0e7;
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    xfer(1'b0, idx[0], HSIZE_WORD, 32'h0, rd);
    check("fuse after reset", rd, rexp(0, {4'h0, fuse[0]}));
    xfer(1'b0, idx[6], HSIZE_WORD, 32'h0, rd);
    check("fuse after reset", rd, rexp(6, {4'h0, fuse[6]}));
    $display("Test second reset done");
    summarize();
  end
endmodule

//--- src/ctb_pkg.sv
// Constants and state type for the converter trim register bank
package ctb_pkg;

  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_B_SINGLE_INA_TIM = 10'h315;
  localparam logic [9:0] IDX_A_SINGLE_INB_TIM = 10'h31a;
  localparam logic [9:0] IDX_B_SINGLE_INB_TIM = 10'h31b;
  localparam logic [9:0] IDX_A_DUAL_INA_OFS   = 10'h344;
  localparam logic [9:0] IDX_A_DUAL_INB_OFS   = 10'h346;
  localparam logic [9:0] IDX_A_SINGLE_INA_OFS = 10'h348;
  localparam logic [9:0] IDX_A_SINGLE_INB_OFS = 10'h34a;
  localparam logic [9:0] IDX_TRIM_CTRL        = 10'h300;
  localparam logic [9:0] IDX_TRIM_STATUS      = 10'h301;

  localparam int unsigned IDX_LSB = 2;
  localparam int unsigned IDX_MSB = 11;

  // Field widths
  localparam int unsigned TIM_W     = 8;
  localparam int unsigned OFS_W     = 12;
  localparam int unsigned OFS_REG_W = 16;

  // Control register bits
  localparam int unsigned CTRL_SINGLE = 0;
  localparam int unsigned CTRL_FG_CAL = 1;
  localparam int unsigned CTRL_A_INB  = 2;
  localparam int unsigned CTRL_B_INB  = 3;
  localparam logic [3:0]  CTRL_RESET  = 4'h0;

  // Status register bits (which outputs carry a live trim)
  localparam int unsigned STAT_A_TIM = 0;
  localparam int unsigned STAT_B_TIM = 1;
  localparam int unsigned STAT_A_OFS = 2;

  // Reserved upper bits of offset registers after reset
  localparam logic [3:0] OFS_RSVD_RESET = 4'h0;

  // AHB encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef struct packed {
    logic [7:0]  tb_ina;
    logic [7:0]  ta_inb;
    logic [7:0]  tb_inb;
    logic [15:0] oa_dual_ina;
    logic [15:0] oa_dual_inb;
    logic [15:0] oa_single_ina;
    logic [15:0] oa_single_inb;
    logic [3:0]  ctrl;
    logic        wr_pend;
    logic [9:0]  wr_idx;
    logic [31:0] rdata;
    logic [7:0]  a_tim;
    logic [7:0]  b_tim;
    logic [11:0] a_ofs;
    logic [2:0]  valid;
  } ctb_state_type;

endpackage

//--- src/ctb_trim_bank.sv
// Converter trim register bank with AHB-Lite register slave
//
// How it works
// - Core B timing uses 0x315 in single mode, calibration on, input A.
// - Core A timing uses 0x31A in single mode, calibration on, input B.
// - Core B timing uses 0x31B in single mode, calibration on, input B.
// - Core A offset uses 0x344 bits 11:0 in dual mode, calibration, input A.
// - Core A offset uses 0x346 in dual mode, calibration on, input B.
// - Core A offset uses 0x348 in single mode, calibration on, input A.
// - Core A offset uses 0x34A in single mode, calibration on, input B.
// - Reset loads every trim from its fuse value, kept until software writes.
// - Trims shift core sampling; software reads factory value and rewrites it.
`timescale 1ns/10ps

module ctb_trim_bank
  import ctb_pkg::*;
(
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic [7:0]  FUSE_B_SINGLE_INA_TIM,
  input  wire logic [7:0]  FUSE_A_SINGLE_INB_TIM,
  input  wire logic [7:0]  FUSE_B_SINGLE_INB_TIM,
  input  wire logic [11:0] FUSE_A_DUAL_INA_OFS,
  input  wire logic [11:0] FUSE_A_DUAL_INB_OFS,
  input  wire logic [11:0] FUSE_A_SINGLE_INA_OFS,
  input  wire logic [11:0] FUSE_A_SINGLE_INB_OFS,
  output logic      [7:0]  CORE_A_TIMING_TRIM,
  output logic             CORE_A_TIMING_VALID,
  output logic      [7:0]  CORE_B_TIMING_TRIM,
  output logic             CORE_B_TIMING_VALID,
  output logic      [11:0] CORE_A_OFFSET_TRIM,
  output logic             CORE_A_OFFSET_VALID
);

  ctb_state_type s_q;
  ctb_state_type s_d;
  ctb_state_type s_rst;
  logic          addr_take;
  logic [9:0]    addr_idx;
  logic          single_q;
  logic          fg_q;
  logic          a_inb_q;
  logic          b_inb_q;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode

  // Zero wait states: every transfer ends in one data phase, always OKAY
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign HRDATA    = s_q.rdata;

  assign addr_take = HSEL && HTRANS[1] && HREADY;
  assign addr_idx  = HADDR[IDX_MSB:IDX_LSB];

  assign single_q = s_q.ctrl[CTRL_SINGLE];
  assign fg_q     = s_q.ctrl[CTRL_FG_CAL];
  assign a_inb_q  = s_q.ctrl[CTRL_A_INB];
  assign b_inb_q  = s_q.ctrl[CTRL_B_INB];

  ////////////////////////////////////////////////////////////////////////////
  // Reset image: fuse values, caught by the synchronous reset

  always_comb begin
    s_rst               = '0;
    s_rst.tb_ina        = FUSE_B_SINGLE_INA_TIM;
    s_rst.ta_inb        = FUSE_A_SINGLE_INB_TIM;
    s_rst.tb_inb        = FUSE_B_SINGLE_INB_TIM;
    s_rst.oa_dual_ina   = {OFS_RSVD_RESET, FUSE_A_DUAL_INA_OFS};
    s_rst.oa_dual_inb   = {OFS_RSVD_RESET, FUSE_A_DUAL_INB_OFS};
    s_rst.oa_single_ina = {OFS_RSVD_RESET, FUSE_A_SINGLE_INA_OFS};
    s_rst.oa_single_inb = {OFS_RSVD_RESET, FUSE_A_SINGLE_INB_OFS};
    s_rst.ctrl          = CTRL_RESET;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d         = s_q;
    s_d.wr_pend = 1'b0;

    // Data phase of a write: commit the word to the addressed register
    if (s_q.wr_pend) begin
      unique case (s_q.wr_idx)
        IDX_B_SINGLE_INA_TIM: s_d.tb_ina        = HWDATA[TIM_W-1:0];
        IDX_A_SINGLE_INB_TIM: s_d.ta_inb        = HWDATA[TIM_W-1:0];
        IDX_B_SINGLE_INB_TIM: s_d.tb_inb        = HWDATA[TIM_W-1:0];
        IDX_A_DUAL_INA_OFS:   s_d.oa_dual_ina   = HWDATA[OFS_REG_W-1:0];
        IDX_A_DUAL_INB_OFS:   s_d.oa_dual_inb   = HWDATA[OFS_REG_W-1:0];
        IDX_A_SINGLE_INA_OFS: s_d.oa_single_ina = HWDATA[OFS_REG_W-1:0];
        IDX_A_SINGLE_INB_OFS: s_d.oa_single_inb = HWDATA[OFS_REG_W-1:0];
        IDX_TRIM_CTRL:        s_d.ctrl          = HWDATA[3:0];
        default: ;
      endcase
    end

    // Address phase: writes of a whole word only; others are dropped
    if (addr_take && HWRITE && HSIZE == HSIZE_WORD) begin
      s_d.wr_pend = 1'b1;
      s_d.wr_idx  = addr_idx;
    end

    // Read data from post-write values, except status from s_q.valid, so a write then read sees new data
    s_d.rdata = '0;
    if (addr_take && !HWRITE) begin
      unique case (addr_idx)
        IDX_B_SINGLE_INA_TIM: s_d.rdata[TIM_W-1:0]     = s_d.tb_ina;
        IDX_A_SINGLE_INB_TIM: s_d.rdata[TIM_W-1:0]     = s_d.ta_inb;
        IDX_B_SINGLE_INB_TIM: s_d.rdata[TIM_W-1:0]     = s_d.tb_inb;
        IDX_A_DUAL_INA_OFS:   s_d.rdata[OFS_REG_W-1:0] = s_d.oa_dual_ina;
        IDX_A_DUAL_INB_OFS:   s_d.rdata[OFS_REG_W-1:0] = s_d.oa_dual_inb;
        IDX_A_SINGLE_INA_OFS: s_d.rdata[OFS_REG_W-1:0] = s_d.oa_single_ina;
        IDX_A_SINGLE_INB_OFS: s_d.rdata[OFS_REG_W-1:0] = s_d.oa_single_inb;
        IDX_TRIM_CTRL:        s_d.rdata[3:0]           = s_d.ctrl;
        IDX_TRIM_STATUS:      s_d.rdata[2:0]           = s_q.valid;
        default: ;
      endcase
    end

    // Trim routing from the updated bank and mode
    s_d.a_tim = '0;
    s_d.b_tim = '0;
    s_d.a_ofs = '0;
    s_d.valid = '0;
    if (s_d.ctrl[CTRL_FG_CAL]) begin
      if (s_d.ctrl[CTRL_SINGLE]) begin
        if (s_d.ctrl[CTRL_B_INB]) begin
          s_d.b_tim = s_d.tb_inb;
        end else begin
          s_d.b_tim = s_d.tb_ina;
        end
        s_d.valid[STAT_B_TIM] = 1'b1;
        if (s_d.ctrl[CTRL_A_INB]) begin
          s_d.a_tim             = s_d.ta_inb;
          s_d.valid[STAT_A_TIM] = 1'b1;
          s_d.a_ofs             = s_d.oa_single_inb[OFS_W-1:0];
        end else begin
          s_d.a_ofs = s_d.oa_single_ina[OFS_W-1:0];
        end
      end else if (s_d.ctrl[CTRL_A_INB]) begin
        s_d.a_ofs = s_d.oa_dual_inb[OFS_W-1:0];
      end else begin
        s_d.a_ofs = s_d.oa_dual_ina[OFS_W-1:0];
      end
      s_d.valid[STAT_A_OFS] = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      s_q <= s_rst;
    end else begin
      s_q <= s_d;
    end
  end

  assign CORE_A_TIMING_TRIM  = s_q.a_tim;
  assign CORE_B_TIMING_TRIM  = s_q.b_tim;
  assign CORE_A_OFFSET_TRIM  = s_q.a_ofs;
  assign CORE_A_TIMING_VALID = s_q.valid[STAT_A_TIM];
  assign CORE_B_TIMING_VALID = s_q.valid[STAT_B_TIM];
  assign CORE_A_OFFSET_VALID = s_q.valid[STAT_A_OFS];

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking ck @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  chk_b_ina_timing: assert property (
    single_q && fg_q && !b_inb_q |-> CORE_B_TIMING_VALID && CORE_B_TIMING_TRIM == s_q.tb_ina)
    else $error("core B input A timing trim not routed");

  chk_a_inb_timing: assert property (
    (CORE_A_TIMING_VALID == (single_q && fg_q && a_inb_q))
    and (CORE_A_TIMING_VALID |-> CORE_A_TIMING_TRIM == s_q.ta_inb))
    else $error("core A input B timing trim wrong");

  chk_b_inb_timing: assert property (
    single_q && fg_q && b_inb_q |-> CORE_B_TIMING_TRIM == s_q.tb_inb)
    else $error("core B input B timing trim not routed");

  chk_dual_ina_ofs: assert property (
    !single_q && fg_q && !a_inb_q |-> CORE_A_OFFSET_TRIM == s_q.oa_dual_ina[11:0])
    else $error("dual input A offset not routed");

  chk_dual_inb_ofs: assert property (
    !single_q && fg_q && a_inb_q |-> CORE_A_OFFSET_TRIM == s_q.oa_dual_inb[11:0])
    else $error("dual input B offset not routed");

  chk_single_ina_ofs: assert property (
    single_q && fg_q && !a_inb_q |-> CORE_A_OFFSET_TRIM == s_q.oa_single_ina[11:0])
    else $error("single input A offset not routed");

  chk_single_inb_ofs: assert property (
    single_q && fg_q && a_inb_q |-> CORE_A_OFFSET_TRIM == s_q.oa_single_inb[11:0])
    else $error("single input B offset not routed");

  chk_fuse_reload: assert property (
    $past(RST) |-> s_q.tb_ina == $past(FUSE_B_SINGLE_INA_TIM)
      && s_q.oa_single_inb[11:0] == $past(FUSE_A_SINGLE_INB_OFS))
    else $error("trim not loaded from fuse at reset");

  chk_write_back: assert property (
    s_q.wr_pend && s_q.wr_idx == IDX_B_SINGLE_INB_TIM
      |=> s_q.tb_inb == $past(HWDATA[7:0]))
    else $error("timing trim write not stored");

  chk_one_per_core: assert property (
    (!fg_q |-> s_q.valid == 3'h0) and (fg_q |-> CORE_A_OFFSET_VALID)
      and (!single_q |-> !CORE_B_TIMING_VALID))
    else $error("trim selection not unique");

  chk_dual_timing_off: assert property (
    !single_q |-> !CORE_A_TIMING_VALID && CORE_A_TIMING_TRIM == 8'h00
      && CORE_B_TIMING_TRIM == 8'h00)
    else $error("timing trim driven in dual mode");

  chk_cal_off_zero: assert property (
    !fg_q |-> CORE_A_OFFSET_TRIM == 12'h000 && CORE_A_TIMING_TRIM == 8'h00
      && CORE_B_TIMING_TRIM == 8'h00)
    else $error("trim driven with calibration off");

  chk_a_timing_off: assert property (
    single_q && fg_q && !a_inb_q |-> !CORE_A_TIMING_VALID && CORE_A_TIMING_TRIM == 8'h00)
    else $error("core A timing trim driven for input A");

  chk_tb_ina_store: assert property (
    s_q.wr_pend && s_q.wr_idx == IDX_B_SINGLE_INA_TIM
      |=> s_q.tb_ina == $past(HWDATA[7:0]))
    else $error("core B input A timing write not stored");

  chk_ta_inb_store: assert property (
    s_q.wr_pend && s_q.wr_idx == IDX_A_SINGLE_INB_TIM
      |=> s_q.ta_inb == $past(HWDATA[7:0]))
    else $error("core A input B timing write not stored");

  chk_dual_ina_store: assert property (
    s_q.wr_pend && s_q.wr_idx == IDX_A_DUAL_INA_OFS
      |=> s_q.oa_dual_ina == $past(HWDATA[15:0]))
    else $error("dual input A offset write not stored");

  chk_dual_inb_store: assert property (
    s_q.wr_pend && s_q.wr_idx == IDX_A_DUAL_INB_OFS
      |=> s_q.oa_dual_inb == $past(HWDATA[15:0]))
    else $error("dual input B offset write not stored");

  chk_single_ina_store: assert property (
    s_q.wr_pend && s_q.wr_idx == IDX_A_SINGLE_INA_OFS
      |=> s_q.oa_single_ina == $past(HWDATA[15:0]))
    else $error("single input A offset write not stored");

  chk_single_inb_store: assert property (
    s_q.wr_pend && s_q.wr_idx == IDX_A_SINGLE_INB_OFS
      |=> s_q.oa_single_inb == $past(HWDATA[15:0]))
    else $error("single input B offset write not stored");

  chk_ctrl_store: assert property (
    s_q.wr_pend && s_q.wr_idx == IDX_TRIM_CTRL
      |=> s_q.ctrl == $past(HWDATA[3:0]))
    else $error("control write not stored");

  chk_nonword_drop: assert property (
    addr_take && HWRITE && HSIZE != HSIZE_WORD |=> !s_q.wr_pend)
    else $error("non-word write accepted");

  chk_rdata_idle: assert property (
    !(addr_take && !HWRITE) |=> HRDATA == 32'h0)
    else $error("read data outside a read data phase");

  chk_read_timing: assert property (
    addr_take && !HWRITE && addr_idx == IDX_B_SINGLE_INA_TIM && !s_q.wr_pend
      |=> HRDATA == {24'h0, $past(s_q.tb_ina)})
    else $error("timing trim read data wrong");

  chk_read_offset: assert property (
    addr_take && !HWRITE && addr_idx == IDX_A_SINGLE_INB_OFS && !s_q.wr_pend
      |=> HRDATA == {16'h0, $past(s_q.oa_single_inb)})
    else $error("offset trim read data wrong");

  chk_status_read: assert property (
    addr_take && !HWRITE && addr_idx == IDX_TRIM_STATUS
      |=> HRDATA == {29'h0, $past(s_q.valid)})
    else $error("status read data wrong");

  chk_fuse_timing: assert property (
    $past(RST) |-> s_q.ta_inb == $past(FUSE_A_SINGLE_INB_TIM)
      && s_q.tb_inb == $past(FUSE_B_SINGLE_INB_TIM))
    else $error("timing trim not loaded from fuse at reset");

  chk_fuse_offset: assert property (
    $past(RST) |-> s_q.oa_dual_ina == {OFS_RSVD_RESET, $past(FUSE_A_DUAL_INA_OFS)}
      && s_q.oa_dual_inb == {OFS_RSVD_RESET, $past(FUSE_A_DUAL_INB_OFS)}
      && s_q.oa_single_ina == {OFS_RSVD_RESET, $past(FUSE_A_SINGLE_INA_OFS)})
    else $error("offset trim not loaded from fuse at reset");

  chk_reset_idle: assert property (
    $past(RST) |-> s_q.valid == 3'h0 && s_q.ctrl == CTRL_RESET && HRDATA == 32'h0)
    else $error("outputs not idle after reset");

  // Trims move only when a write commits, so the cores never see a glitch
  chk_trim_stable: assert property (
    !s_q.wr_pend |=> $stable(CORE_A_OFFSET_TRIM) && $stable(CORE_A_TIMING_TRIM)
      && $stable(CORE_B_TIMING_TRIM) && $stable(s_q.valid))
    else $error("trim output moved without a write");

endmodule
